/* rtl/alu_core.sv */
`timescale 1ns/100ps
module alu_core
  import alu_ops_pkg::*;
(
  input wire op_t op_i,
  input wire logic [7:0] work_i,
  input wire logic [7:0] file_i,
  output logic [7:0] res_o,
  output logic c_o,
  output logic dc_o,
  output logic z_o
);
  logic [7:0] b;
  logic cin;
  logic [8:0] full;
  logic [4:0] lo;

  always_comb begin
    cin = (op_i == OP_SUB);
    b = cin ? ~work_i : work_i; // [RULE3]
    full = {1'b0, file_i} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, file_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    case (op_i)
      OP_ADD: res_o = full[7:0]; // [RULE1]
      OP_SUB: res_o = full[7:0]; // [RULE3]
      OP_AND: res_o = work_i & file_i; // [RULE2]
      OP_SWAP: res_o = {file_i[3:0], file_i[7:4]}; // [RULE4]
      OP_DIR: res_o = work_i;
      default: res_o = 8'h00;
    endcase
    c_o = full[8];
    dc_o = lo[4];
    z_o = (res_o == 8'h00);
  end
endmodule

/* rtl/alu_ops_params.svh */
// Summary of operation
// RULE1: add_work_to_file stores work plus file byte and updates all flags.
// RULE2: and_work_with_file stores work AND file byte and updates only zero.
// RULE3: sub_work_from_file stores file minus work; carry 1 means no borrow.
// RULE4: swap_file_nibbles exchanges the two nibbles and alters no flag.
// RULE5: destination bit 0 writes work, 1 writes the addressed file byte.
// RULE6: load_port_direction copies work to direction 5, 6 or 7, flags kept.
// RULE7: direction registers are plain bus registers too; the load is legacy.
// RULE8: one word, one cycle of four phases: decode, read, process, write.
// RULE9: 14-bit word: 6-bit opcode, destination bit 7, file address 6:0.
`ifndef ALU_OPS_PARAMS_SVH
`define ALU_OPS_PARAMS_SVH

`define OFS_INSTR 12'h000
`define OFS_WORK 12'h004
`define OFS_STATUS 12'h008
`define OFS_DIR5 12'h00c
`define OFS_DIR6 12'h010
`define OFS_DIR7 12'h014
`define FILE_SEL 3'h1

`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_BUSY 8
`define ST_BADOP 9

`define OPC_ADD 6'h07
`define OPC_AND 6'h05
`define OPC_SUB 6'h02
`define OPC_SWAP 6'h0e
`define OPC_MISC 6'h00
`define DIR_SEL 5'h0c
`define DIR_FIRST 3'h5
`define DIR_LAST 3'h7
`define DEST_BIT 7

`define RST_WORK 8'h00
`define RST_DIR 8'hff
`define RST_FILE 8'h00

`endif

/* rtl/alu_ops_pkg.sv */
package alu_ops_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_AND,
    OP_SUB,
    OP_SWAP,
    OP_DIR
  } op_t;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } phase_t;
endpackage

/* rtl/file_register_alu_ops.sv */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "alu_ops_params.svh"
module file_register_alu_ops
  import alu_ops_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [23:0] DIR_O,
  output logic BUSY_O
);
  ////////////////////////////////////////////////////////////////////////
  function automatic op_t decode_op(input logic [13:0] w);
    op_t op;
    op = OP_NONE;
    case (w[13:8]) // [RULE9]
      `OPC_ADD: op = OP_ADD;
      `OPC_AND: op = OP_AND;
      `OPC_SUB: op = OP_SUB;
      `OPC_SWAP: op = OP_SWAP;
      `OPC_MISC:
        if (w[7:3] == `DIR_SEL && w[2:0] >= `DIR_FIRST) begin
          op = OP_DIR; // [RULE6]
        end
      default: op = OP_NONE;
    endcase
    return op;
  endfunction

  phase_t phase_ff;
  op_t op_ff;
  logic [13:0] instr_ff;
  logic [7:0] fop_ff, res_ff, work_ff;
  logic cres_ff, dcres_ff, zres_ff;
  logic c_ff, dc_ff, z_ff, badop_ff;
  logic pready_ff, pslverr_ff;
  logic [7:0] dir_ff [3];
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z;
  logic busy, acc, wr_ok, start, is_file, dest_file, nxt_err;
  logic [6:0] faddr, aidx;
  logic [1:0] didx;
  logic [31:0] nxt_rdata;

  assign busy = (phase_ff != PH_IDLE);
  assign faddr = instr_ff[6:0];
  assign dest_file = instr_ff[`DEST_BIT];
  assign didx = 2'(instr_ff[2:0] - `DIR_FIRST);
  assign aidx = PADDR_I[8:2];
  assign is_file = (PADDR_I[11:9] == `FILE_SEL);
  assign acc = PSEL_I & PENABLE_I & ~pready_ff;
  assign wr_ok = PSEL_I & PENABLE_I & pready_ff & PWRITE_I & ~pslverr_ff;
  assign start = wr_ok & (PADDR_I == `OFS_INSTR);

  alu_core u_alu (
    .op_i(op_ff),
    .work_i(work_ff),
    .file_i(fop_ff),
    .res_o(alu_res),
    .c_o(alu_c),
    .dc_o(alu_dc),
    .z_o(alu_z)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb decode; writes refused while busy so the datapath never races them
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (is_file && PADDR_I[1:0] == 2'h0 && 32'(aidx) < FILE_DEPTH) begin
      nxt_rdata = {24'h000000, file_mem[aidx]};
    end else begin
      case (PADDR_I)
        `OFS_INSTR: nxt_rdata = {18'h00000, instr_ff};
        `OFS_WORK: nxt_rdata = {24'h000000, work_ff};
        `OFS_STATUS: begin
          nxt_rdata[`ST_C] = c_ff;
          nxt_rdata[`ST_DC] = dc_ff;
          nxt_rdata[`ST_Z] = z_ff;
          nxt_rdata[`ST_BUSY] = busy;
          nxt_rdata[`ST_BADOP] = badop_ff;
        end
        `OFS_DIR5: nxt_rdata = {24'h000000, dir_ff[0]}; // [RULE7]
        `OFS_DIR6: nxt_rdata = {24'h000000, dir_ff[1]}; // [RULE7]
        `OFS_DIR7: nxt_rdata = {24'h000000, dir_ff[2]}; // [RULE7]
        default: nxt_err = 1'b1;
      endcase
    end
    if (PWRITE_I && busy) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & nxt_err;
      PRDATA_O <= (acc && !PWRITE_I && !nxt_err) ? nxt_rdata : 32'h0000_0000;
    end
  end
  assign PREADY_O = pready_ff;
  assign PSLVERR_O = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // four phases, one clock each
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      phase_ff <= PH_IDLE;
      BUSY_O <= 1'b0;
    end else begin
      case (phase_ff)
        PH_IDLE: if (start) phase_ff <= PH_DECODE; // [RULE8]
        PH_DECODE: phase_ff <= PH_READ;
        PH_READ: phase_ff <= PH_PROC;
        PH_PROC: phase_ff <= PH_WRITE;
        PH_WRITE: phase_ff <= PH_IDLE;
        default: phase_ff <= PH_IDLE;
      endcase
      BUSY_O <= (phase_ff == PH_IDLE) ? start : (phase_ff != PH_WRITE);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      instr_ff <= 14'h0000;
      op_ff <= OP_NONE;
      fop_ff <= 8'h00;
      res_ff <= 8'h00;
      cres_ff <= 1'b0;
      dcres_ff <= 1'b0;
      zres_ff <= 1'b0;
    end else begin
      if (start) instr_ff <= PWDATA_I[13:0];
      if (phase_ff == PH_DECODE) op_ff <= decode_op(instr_ff); // [RULE9]
      if (phase_ff == PH_READ) fop_ff <= file_mem[faddr]; // [RULE8]
      if (phase_ff == PH_PROC) begin
        res_ff <= alu_res;
        cres_ff <= alu_c;
        dcres_ff <= alu_dc;
        zres_ff <= alu_z;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // work register and flags
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      work_ff <= `RST_WORK;
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
      badop_ff <= 1'b0;
    end else if (phase_ff == PH_WRITE) begin
      if (op_ff != OP_NONE && op_ff != OP_DIR && !dest_file) begin
        work_ff <= res_ff; // [RULE5]
      end
      if (op_ff == OP_ADD || op_ff == OP_SUB) begin
        c_ff <= cres_ff; // [RULE1] [RULE3]
        dc_ff <= dcres_ff;
      end
      if (op_ff == OP_ADD || op_ff == OP_SUB || op_ff == OP_AND) begin
        z_ff <= zres_ff; // [RULE2]
      end
      if (op_ff == OP_NONE) badop_ff <= 1'b1;
    end else if (wr_ok) begin
      if (PADDR_I == `OFS_WORK) work_ff <= PWDATA_I[7:0];
      if (PADDR_I == `OFS_STATUS) begin
        c_ff <= PWDATA_I[`ST_C];
        dc_ff <= PWDATA_I[`ST_DC];
        z_ff <= PWDATA_I[`ST_Z];
        if (PWDATA_I[`ST_BADOP]) badop_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // file bytes and direction registers
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < FILE_DEPTH; i++) file_mem[i] <= `RST_FILE;
    end else if (phase_ff == PH_WRITE && dest_file &&
                 op_ff != OP_NONE && op_ff != OP_DIR) begin
      file_mem[faddr] <= res_ff; // [RULE5]
    end else if (wr_ok && is_file && PADDR_I[1:0] == 2'h0 &&
                 32'(aidx) < FILE_DEPTH) begin
      file_mem[aidx] <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < 3; i++) dir_ff[i] <= `RST_DIR;
    end else if (phase_ff == PH_WRITE && op_ff == OP_DIR) begin
      dir_ff[didx] <= work_ff; // [RULE6]
    end else if (wr_ok) begin
      if (PADDR_I == `OFS_DIR5) dir_ff[0] <= PWDATA_I[7:0]; // [RULE7]
      if (PADDR_I == `OFS_DIR6) dir_ff[1] <= PWDATA_I[7:0]; // [RULE7]
      if (PADDR_I == `OFS_DIR7) dir_ff[2] <= PWDATA_I[7:0]; // [RULE7]
    end
  end
  assign DIR_O = {dir_ff[2], dir_ff[1], dir_ff[0]};

  ////////////////////////////////////////////////////////////////////////
  property p_four_phases;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      start |=> busy [*4] ##1 !busy;
  endproperty
  a_four_phases: assert property (p_four_phases) // [RULE8]
    else $error("instruction did not take four phases");

  property p_decode;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_DECODE && instr_ff[13:8] == `OPC_ADD) |=>
        op_ff == OP_ADD;
  endproperty
  a_decode: assert property (p_decode) // [RULE9]
    else $error("add opcode not decoded");

  property p_add;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_PROC && op_ff == OP_ADD) |=>
        {cres_ff, res_ff} == 9'($past(work_ff)) + 9'($past(fop_ff)) ##1
        (c_ff == cres_ff && z_ff == (res_ff == 8'h00));
  endproperty
  a_add: assert property (p_add) // [RULE1]
    else $error("add result or flags wrong");

  property p_and_flags;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_WRITE && op_ff == OP_AND) |=>
        c_ff == $past(c_ff) && dc_ff == $past(dc_ff) &&
        z_ff == (($past(work_ff) & $past(fop_ff)) == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) // [RULE2]
    else $error("and touched the wrong flags");

  property p_sub_carry;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_WRITE && op_ff == OP_SUB) |=>
        c_ff == ($past(fop_ff) >= $past(work_ff));
  endproperty
  a_sub_carry: assert property (p_sub_carry) // [RULE3]
    else $error("subtract carry polarity wrong");

  property p_swap;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_PROC && op_ff == OP_SWAP) |=>
        res_ff == {fop_ff[3:0], fop_ff[7:4]} ##1
        (c_ff == $past(c_ff, 2) && z_ff == $past(z_ff, 2) &&
         dc_ff == $past(dc_ff, 2));
  endproperty
  a_swap: assert property (p_swap) // [RULE4]
    else $error("swap result wrong or flags changed");

  property p_dest_work;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_WRITE && op_ff != OP_NONE && op_ff != OP_DIR &&
       !dest_file) |=> work_ff == $past(res_ff);
  endproperty
  a_dest_work: assert property (p_dest_work) // [RULE5]
    else $error("result not written to work");

  property p_dest_file;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_WRITE && op_ff != OP_NONE && op_ff != OP_DIR &&
       dest_file) |=>
        file_mem[$past(faddr)] == $past(res_ff) &&
        work_ff == $past(work_ff);
  endproperty
  a_dest_file: assert property (p_dest_file) // [RULE5]
    else $error("result not written back to file");

  property p_dir_load;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (phase_ff == PH_WRITE && op_ff == OP_DIR) |=>
        dir_ff[$past(didx)] == $past(work_ff) && z_ff == $past(z_ff) &&
        c_ff == $past(c_ff);
  endproperty
  a_dir_load: assert property (p_dir_load) // [RULE6]
    else $error("direction load wrong or flags changed");

  property p_dir_bus;
    @(posedge SYS_CLK_I) disable iff (!RESETN_I)
      (wr_ok && PADDR_I == `OFS_DIR6) |=>
        DIR_O[15:8] == 8'($past(PWDATA_I));
  endproperty
  a_dir_bus: assert property (p_dir_bus) // [RULE7]
    else $error("direction register not bus writable");
endmodule

/* test/file_register_alu_ops_tb.sv */
`timescale 1ns/100ps
`include "alu_ops_params.svh"
module file_register_alu_ops_tb;
  import alu_ops_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy, err;
  logic [23:0] dir, edir;
  int errors = 0;
  int n_compared = 0;
  int nbusy = 0;

  file_register_alu_ops uut (
    .SYS_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .DIR_O(dir), .BUSY_O(busy)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  // busy cycles counted apart from the bus traffic
  always @(posedge clk) begin
    if (busy === 1'b1) nbusy <= nbusy + 1;
  end

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // extra edge at the end so the next setup never lands on the release
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk(32'(k), 32'h2, "access cycles");
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
      input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic poll();
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
    end while (rd[`ST_BUSY] !== 1'b0);
  endtask

  task automatic exec(input logic [13:0] word, input logic cb);
    int n0;
    n0 = nbusy;
    apb(1'b1, `OFS_INSTR, {18'h0, word});
    poll();
    if (cb) chk(32'(nbusy - n0), 32'h4, "busy cycles");
  endtask

  function automatic logic [10:0] model(input logic [5:0] op,
      input logic [7:0] w, input logic [7:0] f, input logic [2:0] st);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    s = {1'b0, f} + {1'b0, w};
    n = {1'b0, f[3:0]} + {1'b0, w[3:0]};
    if (op == `OPC_SUB) begin
      s = {1'b0, f} + {1'b0, ~w} + 9'h1;
      n = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h1;
    end
    r = (op == `OPC_AND) ? (w & f) : s[7:0];
    if (op == `OPC_SWAP) return {st, f[3:0], f[7:4]};
    if (op == `OPC_AND) return {r == 8'h0, st[1:0], r};
    return {r == 8'h0, n[4], s[8], r};
  endfunction

  task automatic run(input logic [5:0] op, input logic d,
      input logic [6:0] a, input logic [7:0] w, input logic [7:0] f,
      input logic [2:0] st);
    logic [10:0] e;
    logic [11:0] fa;
    e = model(op, w, f, st);
    fa = 12'h200 + {3'h0, a, 2'h0};
    apb(1'b1, fa, {24'h0, f});
    apb(1'b1, `OFS_WORK, {24'h0, w});
    apb(1'b1, `OFS_STATUS, {29'h0, st});
    exec({op, d, a}, 1'b1);
    rdchk(`OFS_WORK, {24'h0, d ? w : e[7:0]}, "work");
    rdchk(fa, {24'h0, d ? e[7:0] : f}, "file");
    rdchk(`OFS_STATUS, {29'h0, e[10:8]}, "status");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    edir = 24'hffffff;
    chk({8'h0, dir}, {8'h0, edir}, "dir reset");
    rdchk(`OFS_DIR5, 32'hff, "dir5 reset");
    run(`OPC_ADD, 1'b0, 7'h04, 8'h17, 8'hc2, 3'h0);
    run(`OPC_ADD, 1'b1, 7'h7f, 8'h88, 8'h78, 3'h0);
    run(`OPC_ADD, 1'b0, 7'h00, 8'h0f, 8'h01, 3'h7);
    run(`OPC_AND, 1'b1, 7'h04, 8'h17, 8'hc2, 3'h3);
    run(`OPC_AND, 1'b0, 7'h05, 8'h0f, 8'hf0, 3'h0);
    for (int i = 1; i <= 3; i++) begin
      run(`OPC_SUB, 1'b1, 7'h10, 8'h02, 8'(i), 3'h4);
    end
    run(`OPC_SUB, 1'b0, 7'h11, 8'h21, 8'h13, 3'h0);
    run(`OPC_SWAP, 1'b0, 7'h20, 8'h00, 8'ha5, 3'h7);
    run(`OPC_SWAP, 1'b1, 7'h21, 8'h33, 8'h5c, 3'h0);
    // legacy direction load, flags preset to prove they stay
    apb(1'b1, `OFS_STATUS, 32'h5);
    for (int f = 5; f <= 7; f++) begin
      apb(1'b1, `OFS_WORK, 32'(f * 8'h11));
      exec(14'h0060 | 14'(f), 1'b1);
      edir[(f - 5) * 8 +: 8] = 8'(f * 8'h11);
      chk({8'h0, dir}, {8'h0, edir}, "dir load");
    end
    rdchk(`OFS_DIR7, 32'h77, "dir7 read");
    rdchk(`OFS_STATUS, 32'h5, "flags kept");
    exec(14'h0064, 1'b0);
    chk({8'h0, dir}, {8'h0, edir}, "bad operand");
    rdchk(`OFS_STATUS, 32'h205, "bad op flag");
    apb(1'b1, `OFS_STATUS, 32'h200);
    apb(1'b1, `OFS_DIR6, 32'h3c);
    edir[15:8] = 8'h3c;
    chk({8'h0, dir}, {8'h0, edir}, "dir direct");
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped");
    // write landing mid-instruction must be refused
    apb(1'b1, `OFS_WORK, 32'h11);
    apb(1'b1, `OFS_INSTR, {18'h0, `OPC_SWAP, 8'h80});
    apb(1'b1, `OFS_WORK, 32'h99);
    chk({31'h0, err}, 32'h1, "busy write");
    poll();
    rdchk(`OFS_WORK, 32'h11, "work kept");
    rdchk(12'h200, 32'h10, "swap in place");
    conclude();
  end
endmodule
